// >>> verilog/psmlu_map.svh
// Purpose: Encodings, field positions and register map of the media unit
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef PSMLU_MAP_SVH
`define PSMLU_MAP_SVH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define TOP_HI      31
`define TOP_LO      30
`define RD_HI       29
`define RD_LO       25
`define MAJ_HI      24
`define MAJ_LO      19
`define RS1_HI      18
`define RS1_LO      14
`define OPF_HI      13
`define OPF_LO      5
`define RS2_HI      4
`define RS2_LO      0
`define TOP_CODE    2'b10
`define MAJ_CODE    6'h36
`define IDX_ZERO    5'h00

// ----------------------------------------
// Extended opcodes
// ----------------------------------------
`define OPF_MERGE   9'h04b
`define OPF_SUB16   9'h054
`define OPF_SUB16S  9'h055
`define OPF_SUB32   9'h056
`define OPF_SUB32S  9'h057
`define OPF_ZERO    9'h060
`define OPF_ZEROS   9'h061
`define OPF_ONE     9'h07e
`define OPF_ONES    9'h07f
`define OPF_SRC1    9'h074
`define OPF_SRC1S   9'h075
`define OPF_SRC2    9'h078
`define OPF_SRC2S   9'h079
`define OPF_NOT1    9'h06a
`define OPF_NOT1S   9'h06b
`define OPF_NOT2    9'h066
`define OPF_NOT2S   9'h067

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_STATUS 4'h0
`define ADDR_MASK   4'h4
`define ST_DONE     0
`define ST_BADOP    1
`define ST_FPOFF    2
`define ST_RST      3'h0
`define MASK_RST    3'h0
`define SINGLE_HI   31
`define UPPER_LO    32

`endif

// >>> verilog/psmlu_pkg.sv
// Purpose: Types shared by the media unit
// Assumes: Nothing is imported; users write psmlu_pkg::name
// Notes:   Numbers live in psmlu_map.svh
package psmlu_pkg;

  // ----------------------------------------
  // Operation classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE  = 4'b0000,
    OP_MERGE = 4'b0001,
    OP_SUB16 = 4'b0010,
    OP_SUB32 = 4'b0011,
    OP_ZERO  = 4'b0100,
    OP_ONE   = 4'b0101,
    OP_SRC1  = 4'b0110,
    OP_SRC2  = 4'b0111,
    OP_NOT1  = 4'b1000,
    OP_NOT2  = 4'b1001
  } op_e;

  // Register-file write-back bundle
  typedef struct packed {
    logic        en;
    logic        single;
    logic [4:0]  index;
    logic [63:0] data;
  } wb_s;

  // Trap bundle, one per instruction
  typedef struct packed {
    logic claim;
    logic bad_opcode;
    logic fpu_off;
  } trap_s;

endpackage

// >>> verilog/partitioned_sub_merge_logic_unit.sv
// Purpose: Partitioned subtract, fill, copy and invert on FP registers
// Assumes: Core presents instruction and both source values in one cycle
// Notes:   Result or trap appears one cycle after issue
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "psmlu_map.svh"

// Operation
// - Byte interleave defined: first, second alternating
// - Byte interleave always raises bad-opcode trap
// - Wide subtract: four halfword or two word lanes
// - Lane result is first minus second source
// - Single subtract: two halfword or one word
// - Lanes wrap, borrow dropped, no flags
// - Subtract with FPU off raises FPU-off trap
// - Wide fills write all zeros or ones
// - Single fills write zeros or ones
// - Fill with nonzero source fields traps
// - Fill with FPU off raises FPU-off trap
// - Wide copy or invert of either source
// - Same copy and invert on single registers
// - First-source ops need second field zero
// - Second-source ops need first field zero
// - Copy or invert with FPU off traps
// - First-source copy leaves FP state untouched
module partitioned_sub_merge_logic_unit #(
  parameter int unsigned H_LANES = 4,
  parameter int unsigned W_LANES = 2
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_issue,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_src1,
  input  wire logic [63:0] i_src2,
  input  wire logic        i_fpu_present,
  input  wire logic        i_fp_status_enable_bit,
  input  wire logic        i_processor_state_fpu_enable_bit,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic             o_claim,
  output logic             o_wr_en,
  output logic             o_wr_single,
  output logic [4:0]       o_wr_index,
  output logic [63:0]      o_wr_data,
  output logic             o_bad_opcode_trap,
  output logic             o_fpu_off_trap,
  output logic [31:0]      o_rdata,
  output logic             o_irq
);

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  wire logic [1:0] top_field;
  wire logic [5:0] major_field;
  wire logic [4:0] dest_index;
  wire logic [4:0] first_source_index;
  wire logic [4:0] second_source_index;
  wire logic [8:0] opf;
  wire logic       in_group;

  // Fixed fields pick out this instruction group
  assign top_field           = i_instr[`TOP_HI:`TOP_LO];
  assign major_field         = i_instr[`MAJ_HI:`MAJ_LO];
  assign dest_index          = i_instr[`RD_HI:`RD_LO];
  assign first_source_index  = i_instr[`RS1_HI:`RS1_LO];
  assign second_source_index = i_instr[`RS2_HI:`RS2_LO];
  assign opf                 = i_instr[`OPF_HI:`OPF_LO];
  assign in_group = i_issue && (top_field == `TOP_CODE) && (major_field == `MAJ_CODE);

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  psmlu_pkg::op_e op;
  logic           single;

  // Unknown opf stays unclaimed for other units of the group
  always_comb
  begin
    op     = psmlu_pkg::OP_NONE;
    single = 1'b0;
    case (opf)
      `OPF_MERGE:  op = psmlu_pkg::OP_MERGE;
      `OPF_SUB16:  op = psmlu_pkg::OP_SUB16;
      `OPF_SUB16S:
      begin
        op     = psmlu_pkg::OP_SUB16;
        single = 1'b1;
      end
      `OPF_SUB32:  op = psmlu_pkg::OP_SUB32;
      `OPF_SUB32S:
      begin
        op     = psmlu_pkg::OP_SUB32;
        single = 1'b1;
      end
      `OPF_ZERO:   op = psmlu_pkg::OP_ZERO;
      `OPF_ZEROS:
      begin
        op     = psmlu_pkg::OP_ZERO;
        single = 1'b1;
      end
      `OPF_ONE:    op = psmlu_pkg::OP_ONE;
      `OPF_ONES:
      begin
        op     = psmlu_pkg::OP_ONE;
        single = 1'b1;
      end
      `OPF_SRC1:   op = psmlu_pkg::OP_SRC1;
      `OPF_SRC1S:
      begin
        op     = psmlu_pkg::OP_SRC1;
        single = 1'b1;
      end
      `OPF_SRC2:   op = psmlu_pkg::OP_SRC2;
      `OPF_SRC2S:
      begin
        op     = psmlu_pkg::OP_SRC2;
        single = 1'b1;
      end
      `OPF_NOT1:   op = psmlu_pkg::OP_NOT1;
      `OPF_NOT1S:
      begin
        op     = psmlu_pkg::OP_NOT1;
        single = 1'b1;
      end
      `OPF_NOT2:   op = psmlu_pkg::OP_NOT2;
      `OPF_NOT2S:
      begin
        op     = psmlu_pkg::OP_NOT2;
        single = 1'b1;
      end
      default:     op = psmlu_pkg::OP_NONE;
    endcase
  end

  // ----------------------------------------
  // Trap qualification
  // ----------------------------------------
  wire logic known;
  wire logic is_fill;
  wire logic uses_first;
  wire logic uses_second;
  wire logic rs1_bad;
  wire logic rs2_bad;
  wire logic fpu_on;
  wire logic bad_op;
  wire logic fpu_off;
  wire logic do_write;

  // Reserved source fields must be zero for fills and one-source ops
  assign known       = in_group && (op != psmlu_pkg::OP_NONE);
  assign is_fill     = (op == psmlu_pkg::OP_ZERO) || (op == psmlu_pkg::OP_ONE);
  assign uses_first  = (op == psmlu_pkg::OP_SRC1) || (op == psmlu_pkg::OP_NOT1);
  assign uses_second = (op == psmlu_pkg::OP_SRC2) || (op == psmlu_pkg::OP_NOT2);
  assign rs1_bad     = (is_fill || uses_second) && (first_source_index != `IDX_ZERO);
  assign rs2_bad     = (is_fill || uses_first) && (second_source_index != `IDX_ZERO);
  assign fpu_on      = i_fpu_present && i_fp_status_enable_bit && i_processor_state_fpu_enable_bit;
  // Interleave is left to software even with the FPU on
  assign bad_op      = known && ((op == psmlu_pkg::OP_MERGE) || rs1_bad || rs2_bad);
  // Bad opcode outranks FPU-off, so only one trap per instruction
  assign fpu_off     = known && !bad_op && !fpu_on;
  assign do_write    = known && !bad_op && fpu_on;

  // ----------------------------------------
  // Lane arithmetic
  // ----------------------------------------
  logic [63:0] diff16;
  logic [63:0] diff32;

  // Each lane wraps on its own; no borrow crosses a lane edge
  genvar g;
  generate
    for (g = 0; g < H_LANES; g++)
    begin : g_half
      assign diff16[g*16 +: 16] = i_src1[g*16 +: 16] - i_src2[g*16 +: 16];
    end
    for (g = 0; g < W_LANES; g++)
    begin : g_word
      assign diff32[g*32 +: 32] = i_src1[g*32 +: 32] - i_src2[g*32 +: 32];
    end
  endgenerate

  // ----------------------------------------
  // Result select
  // ----------------------------------------
  logic [63:0] wide_res;
  wire  logic [63:0] single_mask;
  wire  logic [63:0] next_data;

  // Interleave result is never built: that opcode always traps
  always_comb
  begin
    case (op)
      psmlu_pkg::OP_SUB16: wide_res = diff16;
      psmlu_pkg::OP_SUB32: wide_res = diff32;
      psmlu_pkg::OP_ZERO:  wide_res = '0;
      psmlu_pkg::OP_ONE:   wide_res = '1;
      psmlu_pkg::OP_SRC1:  wide_res = i_src1;
      psmlu_pkg::OP_SRC2:  wide_res = i_src2;
      psmlu_pkg::OP_NOT1:  wide_res = ~i_src1;
      psmlu_pkg::OP_NOT2:  wide_res = ~i_src2;
      default:             wide_res = '0;
    endcase
  end

  // Single-width results sit in the low word, upper word cleared
  assign single_mask = single ? {{(64-`UPPER_LO){1'b0}}, {`UPPER_LO{1'b1}}} : '1;
  assign next_data   = wide_res & single_mask;

  // ----------------------------------------
  // Write-back and trap registers
  // ----------------------------------------
  psmlu_pkg::wb_s   wb;
  psmlu_pkg::trap_s trap;
  wire  psmlu_pkg::wb_s   next_wb;
  wire  psmlu_pkg::trap_s next_trap;

  // Only the data register is written; no state-register path exists
  assign next_wb   = '{en: do_write, single: single, index: dest_index, data: next_data};
  assign next_trap = '{claim: known, bad_opcode: bad_op, fpu_off: fpu_off};

  // One-cycle result stage
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wb   <= '0;
      trap <= '0;
    end
    else
    begin
      wb   <= next_wb;
      trap <= next_trap;
    end
  end

  assign o_wr_en           = wb.en;
  assign o_wr_single       = wb.single;
  assign o_wr_index        = wb.index;
  assign o_wr_data         = wb.data;
  assign o_claim           = trap.claim;
  assign o_bad_opcode_trap = trap.bad_opcode;
  assign o_fpu_off_trap    = trap.fpu_off;

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [31:0] rdata;
  logic        irq;
  wire  logic       sel_status;
  wire  logic       sel_mask;
  wire  logic [2:0] events;
  wire  logic [2:0] next_status;
  wire  logic [2:0] next_mask;
  wire  logic [31:0] next_rdata;

  // Read of status clears it, but a same-cycle event still lands
  assign sel_status  = (i_addr == `ADDR_STATUS);
  assign sel_mask    = (i_addr == `ADDR_MASK);
  assign events      = {fpu_off, bad_op, do_write};
  assign next_status = ((i_rd && sel_status) ? `ST_RST : status) | events;
  assign next_mask   = (i_wr && sel_mask) ? i_wdata[2:0] : mask;
  assign next_rdata  = !i_rd ? '0 :
                       sel_status ? {29'h0, status} :
                       sel_mask   ? {29'h0, mask} : '0;

  // Irq follows the status it reflects in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status <= `ST_RST;
      mask   <= `MASK_RST;
      rdata  <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask   <= next_mask;
      rdata  <= next_rdata;
      irq    <= |(next_status & next_mask);
    end
  end

  assign o_rdata = rdata;
  assign o_irq   = irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Results, traps and interrupt, one cycle after issue
  merge_always_traps_a : assert property (in_group && opf == `OPF_MERGE |=> o_bad_opcode_trap && !o_wr_en)
    else $error("interleave not trapped");
  sub_lane_order_a : assert property (do_write && op == psmlu_pkg::OP_SUB16 && !single |=>
    o_wr_data[63:48] == $past(i_src1[63:48]) - $past(i_src2[63:48]))
    else $error("halfword lane not first minus second");
  word_lane_wrap_a : assert property (do_write && op == psmlu_pkg::OP_SUB32 |=>
    o_wr_data[31:0] == $past(i_src1[31:0]) - $past(i_src2[31:0]))
    else $error("word lane result wrong");
  fpu_off_trap_a : assert property (known && !bad_op && !fpu_on |=> o_fpu_off_trap && !o_wr_en)
    else $error("missing FPU-off trap");
  fill_ones_a : assert property (do_write && op == psmlu_pkg::OP_ONE && !single |=> o_wr_data == '1)
    else $error("wide one-fill wrong");
  fill_fields_a : assert property (in_group && opf == `OPF_ZERO && first_source_index != `IDX_ZERO
    |=> o_bad_opcode_trap)
    else $error("fill reserved field not trapped");
  src1_field_a : assert property (in_group && opf == `OPF_SRC1 && second_source_index != `IDX_ZERO
    |=> o_bad_opcode_trap && !o_fpu_off_trap)
    else $error("first-source reserved field not trapped");
  src2_copy_a : assert property (do_write && op == psmlu_pkg::OP_SRC2 && !single
    |=> o_wr_data == $past(i_src2) && o_wr_index == $past(dest_index))
    else $error("second-source copy wrong");
  single_upper_a : assert property (o_wr_en && o_wr_single |-> o_wr_data[63:`UPPER_LO] == '0)
    else $error("single result upper word not clear");
  one_trap_a : assert property ((o_bad_opcode_trap || o_fpu_off_trap) |->
    !o_wr_en && !(o_bad_opcode_trap && o_fpu_off_trap))
    else $error("trap and write together");
  irq_status_a : assert property (|(events & mask) && !(i_wr && sel_mask) |=> o_irq)
    else $error("unmasked event without irq");

  // Remaining lanes, fills and reserved fields; the bench reaches each one
  half_lane_low_a : assert property (do_write && op == psmlu_pkg::OP_SUB16 |=>
    o_wr_data[15:0] == $past(i_src1[15:0]) - $past(i_src2[15:0]))
    else $error("low halfword lane wrong");
  word_lane_high_a : assert property (do_write && op == psmlu_pkg::OP_SUB32 && !single |=>
    o_wr_data[63:`UPPER_LO] == $past(i_src1[63:`UPPER_LO]) - $past(i_src2[63:`UPPER_LO]))
    else $error("upper word lane wrong");
  single_sub_a : assert property (do_write && single &&
    (op == psmlu_pkg::OP_SUB16 || op == psmlu_pkg::OP_SUB32) |=> o_wr_single && o_wr_data[63:`UPPER_LO] == '0)
    else $error("single subtract not single width");
  single_half_a : assert property (do_write && single && op == psmlu_pkg::OP_SUB16 |=>
    o_wr_data[31:16] == $past(i_src1[31:16]) - $past(i_src2[31:16]))
    else $error("single halfword lane wrong");
  fill_zeros_a : assert property (do_write && op == psmlu_pkg::OP_ZERO |=> o_wr_data == '0)
    else $error("zero-fill not all zeros");
  fill_single_a : assert property (do_write && op == psmlu_pkg::OP_ONE && single |=>
    o_wr_data[`SINGLE_HI:0] == '1 && o_wr_data[63:`UPPER_LO] == '0)
    else $error("single one-fill wrong");
  fill_rs2_field_a : assert property (in_group && is_fill && second_source_index != `IDX_ZERO |=>
    o_bad_opcode_trap && !o_fpu_off_trap && !o_wr_en)
    else $error("fill second field not trapped");
  fill_fpu_off_a : assert property (in_group && is_fill && !rs1_bad && !rs2_bad && !fpu_on |=>
    o_fpu_off_trap && !o_wr_en)
    else $error("fill with FPU off not trapped");
  src2_field_a : assert property (in_group && uses_second && first_source_index != `IDX_ZERO |=>
    o_bad_opcode_trap && !o_fpu_off_trap && !o_wr_en)
    else $error("second-source reserved field not trapped");
  invert_first_a : assert property (do_write && op == psmlu_pkg::OP_NOT1 |=>
    o_wr_data[`SINGLE_HI:0] == ~$past(i_src1[`SINGLE_HI:0]))
    else $error("first-source invert wrong");
  copy_fpu_off_a : assert property (in_group && (uses_first || uses_second) && !fpu_on &&
    !rs1_bad && !rs2_bad |=> o_fpu_off_trap && !o_wr_en)
    else $error("copy with FPU off not trapped");
  foreign_ignored_a : assert property (!in_group |=> !o_claim && !o_wr_en)
    else $error("foreign instruction claimed");

  // Scenarios the bench must reach
  sub_done_c   : cover property (do_write && op == psmlu_pkg::OP_SUB16 ##1 o_wr_en);
  merge_trap_c : cover property (in_group && opf == `OPF_MERGE ##1 o_bad_opcode_trap);
  fpu_off_c    : cover property (fpu_off ##1 o_fpu_off_trap);
  read_clear_c : cover property (i_rd && sel_status && status != `ST_RST ##1 status == `ST_RST);
  fill_trap_c  : cover property (in_group && is_fill && rs1_bad ##1 o_bad_opcode_trap);

endmodule // partitioned_sub_merge_logic_unit

// >>> dv/partitioned_sub_merge_logic_unit_bench.sv
// Purpose: Self-checking bench for the partitioned subtract and logic unit
// Assumes: Result or trap one cycle after issue; status at 0x0, mask at 0x4
// Notes:   Expectations ride a one-stage pipe and are compared mid-cycle
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("FAIL %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module partitioned_sub_merge_logic_unit_bench;
  typedef struct packed {
    logic        claim;
    logic        wr;
    logic        bad;
    logic        off;
    logic        single;
    logic [4:0]  idx;
    logic [63:0] data;
  } exp_s;

  // Lanes chosen so a swapped operand order or a leaking borrow shows
  localparam logic [63:0] SRC_A = 64'h8000_0001_0000_7fff;
  localparam logic [63:0] SRC_B = 64'h0001_0002_0001_ffff;

  logic        i_clk;
  logic        i_nrst;
  logic        i_issue;
  logic [31:0] i_instr;
  logic [63:0] i_src1;
  logic [63:0] i_src2;
  logic        i_fpu_present;
  logic        i_fp_status_enable_bit;
  logic        i_processor_state_fpu_enable_bit;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        o_claim;
  logic        o_wr_en;
  logic        o_wr_single;
  logic [4:0]  o_wr_index;
  logic [63:0] o_wr_data;
  logic        o_bad_opcode_trap;
  logic        o_fpu_off_trap;
  logic [31:0] o_rdata;
  logic        o_irq;
  exp_s        exp_d;
  exp_s        exp_q;
  logic [2:0]  en;
  int          num_errors;
  int          checks_done;

  partitioned_sub_merge_logic_unit DUT (
    .i_clk                            (i_clk),
    .i_nrst                           (i_nrst),
    .i_issue                          (i_issue),
    .i_instr                          (i_instr),
    .i_src1                           (i_src1),
    .i_src2                           (i_src2),
    .i_fpu_present                    (i_fpu_present),
    .i_fp_status_enable_bit           (i_fp_status_enable_bit),
    .i_processor_state_fpu_enable_bit (i_processor_state_fpu_enable_bit),
    .i_addr                           (i_addr),
    .i_wdata                          (i_wdata),
    .i_wr                             (i_wr),
    .i_rd                             (i_rd),
    .o_claim                          (o_claim),
    .o_wr_en                          (o_wr_en),
    .o_wr_single                      (o_wr_single),
    .o_wr_index                       (o_wr_index),
    .o_wr_data                        (o_wr_data),
    .o_bad_opcode_trap                (o_bad_opcode_trap),
    .o_fpu_off_trap                   (o_fpu_off_trap),
    .o_rdata                          (o_rdata),
    .o_irq                            (o_irq)
  );

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  // Expectation follows the issue by exactly one edge
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      exp_q <= '0;
    else
      exp_q <= exp_d;
  end

  // Mid-cycle compare, so every registered output has landed
  always @(negedge i_clk)
  begin
    if (i_nrst)
    begin
      `CHK(o_claim, exp_q.claim)
      `CHK(o_wr_en, exp_q.wr)
      `CHK(o_bad_opcode_trap, exp_q.bad)
      `CHK(o_fpu_off_trap, exp_q.off)
      if (exp_q.wr)
      begin
        `CHK(o_wr_single, exp_q.single)
        `CHK(o_wr_index, exp_q.idx)
        `CHK(o_wr_data, exp_q.data)
      end
    end
  end

  // Lane-wise wrapped difference, unused upper lanes zero
  function automatic logic [63:0] sub(input logic [63:0] a, input logic [63:0] b, input int w, input int n);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < n; k++)
    begin
      if (w == 16)
        r[16*k +: 16] = a[16*k +: 16] - b[16*k +: 16];
      else
        r[32*k +: 32] = a[32*k +: 32] - b[32*k +: 32];
    end
    return r;
  endfunction

  function automatic logic [63:0] lo(input logic [63:0] x);
    return {32'h0000_0000, x[31:0]};
  endfunction

  function automatic logic [31:0] mk(input logic [8:0] opf, input logic [4:0] f1, input logic [4:0] f2);
    return {2'b10, opf[4:0] ^ 5'h15, 6'h36, f1, opf, f2};
  endfunction

  // Kind: 0 ignored, 1 write, 2 bad opcode, 3 FPU off
  task automatic op(input logic [31:0] ins, input logic [1:0] kind, input logic [63:0] res);
    exp_s e;
    e = '0;
    e.claim = (kind != 2'd0);
    e.wr = (kind == 2'd1);
    e.bad = (kind == 2'd2);
    e.off = (kind == 2'd3);
    e.single = ins[5];
    e.idx = ins[29:25];
    e.data = res;
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_instr <= ins;
    exp_d <= e;
  endtask

  task automatic idle(input logic [2:0] ena);
    @(posedge i_clk);
    i_issue <= 1'b0;
    {i_fpu_present, i_fp_status_enable_bit, i_processor_state_fpu_enable_bit} <= ena;
    exp_d <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    `CHK(o_rdata, v)
  endtask

  // Irq is registered from the same next value as status; the check still waits two edges
  task automatic irq_chk(input logic v);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_irq, v)
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far beyond the hundred or so cycles of the tests
  initial
  begin
    #20000;
    num_errors++;
    tally_and_finish;
  end

  initial
  begin
    {i_clk, i_nrst, i_issue, i_wr, i_rd} = '0;
    {i_instr, i_addr, i_wdata} = '0;
    {i_fpu_present, i_fp_status_enable_bit, i_processor_state_fpu_enable_bit} = 3'h7;
    i_src1 = SRC_A;
    i_src2 = SRC_B;
    exp_d = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h4, 32'h0);
    op(mk(9'h054, 5'h03, 5'h04), 2'd1, sub(SRC_A, SRC_B, 16, 4));
    op(mk(9'h056, 5'h05, 5'h06), 2'd1, sub(SRC_A, SRC_B, 32, 2));
    op(mk(9'h055, 5'h07, 5'h08), 2'd1, sub(SRC_A, SRC_B, 16, 2));
    op(mk(9'h057, 5'h09, 5'h0a), 2'd1, sub(SRC_A, SRC_B, 32, 1));
    idle(3'h7);
    rd_chk(4'h0, 32'h1);
    rd_chk(4'h0, 32'h0);
    op(mk(9'h050, 5'h01, 5'h02), 2'd0, '0);
    op(mk(9'h054, 5'h01, 5'h02) ^ 32'h0008_0000, 2'd0, '0);
    op(mk(9'h054, 5'h01, 5'h02) ^ 32'h4000_0000, 2'd0, '0);
    idle(3'h7);
    rd_chk(4'h0, 32'h0);
    op(mk(9'h060, 5'h00, 5'h00), 2'd1, 64'h0);
    op(mk(9'h07e, 5'h00, 5'h00), 2'd1, 64'hffff_ffff_ffff_ffff);
    op(mk(9'h061, 5'h00, 5'h00), 2'd1, 64'h0);
    op(mk(9'h07f, 5'h00, 5'h00), 2'd1, 64'h0000_0000_ffff_ffff);
    op(mk(9'h060, 5'h01, 5'h00), 2'd2, '0);
    op(mk(9'h07f, 5'h00, 5'h10), 2'd2, '0);
    op(mk(9'h074, 5'h07, 5'h00), 2'd1, SRC_A);
    op(mk(9'h078, 5'h00, 5'h09), 2'd1, SRC_B);
    op(mk(9'h06a, 5'h0b, 5'h00), 2'd1, ~SRC_A);
    op(mk(9'h066, 5'h00, 5'h0c), 2'd1, ~SRC_B);
    op(mk(9'h075, 5'h0d, 5'h00), 2'd1, lo(SRC_A));
    op(mk(9'h079, 5'h00, 5'h0e), 2'd1, lo(SRC_B));
    op(mk(9'h06b, 5'h0f, 5'h00), 2'd1, lo(~SRC_A));
    op(mk(9'h067, 5'h00, 5'h11), 2'd1, lo(~SRC_B));
    op(mk(9'h074, 5'h07, 5'h01), 2'd2, '0);
    op(mk(9'h06b, 5'h07, 5'h10), 2'd2, '0);
    op(mk(9'h079, 5'h02, 5'h00), 2'd2, '0);
    op(mk(9'h066, 5'h1f, 5'h03), 2'd2, '0);
    op(mk(9'h04b, 5'h01, 5'h02), 2'd2, '0);
    idle(3'h7);
    rd_chk(4'h0, 32'h3);
    // Each enable dropped alone, then a subtract, a fill, a copy, an interleave and a bad fill
    for (int k = 0; k < 3; k++)
    begin
      en = 3'h7 ^ (3'h1 << k);
      idle(en);
      op(mk(9'h054, 5'h01, 5'h02), 2'd3, '0);
      op(mk(9'h061, 5'h00, 5'h00), 2'd3, '0);
      op(mk(9'h078, 5'h00, 5'h02), 2'd3, '0);
      op(mk(9'h04b, 5'h01, 5'h02), 2'd2, '0);
      op(mk(9'h07e, 5'h04, 5'h00), 2'd2, '0);
    end
    idle(3'h7);
    rd_chk(4'h0, 32'h6);
    wr(4'h4, 32'hffff_fff4);
    rd_chk(4'h4, 32'h4);
    idle(3'h3);
    op(mk(9'h057, 5'h01, 5'h02), 2'd3, '0);
    idle(3'h7);
    irq_chk(1'b1);
    wr(4'h4, 32'h0);
    irq_chk(1'b0);
    wr(4'h4, 32'h4);
    irq_chk(1'b1);
    rd_chk(4'h0, 32'h4);
    irq_chk(1'b0);
    op(mk(9'h04b, 5'h01, 5'h02), 2'd2, '0);
    idle(3'h7);
    irq_chk(1'b0);
    wr(4'h0, 32'h7);
    rd_chk(4'h0, 32'h2);
    rd_chk(4'h8, 32'h0);
    tally_and_finish;
  end
endmodule // partitioned_sub_merge_logic_unit_bench
